// ===== hw/see_pkg.sv
package see_pkg;

    localparam int          CLK_PERIOD_NS = 10;
    localparam int          PROG_TIME_NS  = 5_000_000;
    localparam int          PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int          TMR_W         = 19;
    localparam int          ADDR_W        = 9;
    localparam int          PAGE_BYTES    = 16;
    localparam int          X_BIT         = 3;
    localparam int          SR_BP_LO      = 2;
    localparam logic        HAS_UPPER     = 1'b1;
    localparam logic [2:0]  CNT_LAST      = 3'h7;
    localparam logic [3:0]  SR_FILL       = 4'hf;
    localparam logic [7:0]  OP_SET_LATCH  = 8'h06;
    localparam logic [7:0]  OP_CLR_LATCH  = 8'h04;
    localparam logic [7:0]  OP_STAT_RD    = 8'h05;
    localparam logic [7:0]  OP_STAT_WR    = 8'h01;
    localparam logic [7:0]  OP_MEM_MASK   = 8'hf7;
    localparam logic [7:0]  OP_MEM_RD     = 8'h03;
    localparam logic [7:0]  OP_MEM_WR     = 8'h02;

    typedef enum logic [2:0] {
        L_CMD  = 3'h0,
        L_ADDR = 3'h1,
        L_DATA = 3'h3,
        L_OUT  = 3'h2,
        L_DROP = 3'h6
    } see_lstate_e;

    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_SET  = 3'h1,
        K_CLR  = 3'h2,
        K_SRD  = 3'h3,
        K_SWR  = 3'h4,
        K_MRD  = 3'h5,
        K_MWR  = 3'h6
    } see_kind_e;

    typedef struct packed {
        see_lstate_e        st;
        logic               live;
        logic [2:0]         cnt;
        logic [6:0]         sh;
        see_kind_e          kind;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         out;
    } see_link_s;

    typedef struct packed {
        logic               set;
        logic               clr;
        logic               swr;
        logic               mwr;
        logic [7:0]         srb;
        logic [15:0]        mask;
        logic [4:0]         page;
    } see_rec_s;

    typedef struct packed {
        logic               cs_m;
        logic               cs_s;
        logic               cs_p;
        logic               wg_m;
        logic               wg_s;
        logic               busy;
        logic               standby;
        logic               wel;
        logic [1:0]         bp;
        logic [TMR_W-1:0]   tmr;
    } see_ref_s;

    typedef struct packed {
        logic [7:0]         m;
        logic [7:0]         s;
    } see_sync_s;

    typedef struct packed {
        logic               bit_o;
        logic               oe_n;
    } see_pin_s;

    localparam see_link_s LINK_RST = '{st: L_CMD, kind: K_NONE,
                                       default: '0};
    localparam see_rec_s  REC_RST  = '{default: '0};
    localparam see_ref_s  REF_RST  = '{cs_m: 1'b1, cs_s: 1'b1,
                                       cs_p: 1'b1, default: '0};
    localparam see_pin_s  PIN_RST  = '{bit_o: 1'b0, oe_n: 1'b1};

endpackage : see_pkg

// ===== hw/see_cmd_port.sv
`timescale 1ns/10ps
module see_cmd_port
    import see_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic pause_n,
    input  wire logic write_guard_n,
    output logic      so,
    output logic      so_oe_n,
    output logic      busy,
    output logic      standby
);

    see_link_s  lk_q;
    see_link_s  lk_d;
    see_rec_s   rec_q;
    see_rec_s   rec_d;
    see_ref_s   rf_q;
    see_ref_s   rf_d;
    see_sync_s  sy_q;
    see_sync_s  sy_d;
    see_pin_s   pin_q;
    see_pin_s   pin_d;
    logic [7:0] mem  [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:PAGE_BYTES-1];
    logic [7:0] bin;
    logic [7:0] stat_word;
    logic       buf_we;
    logic       mem_we;
    logic       cs_rise;
    logic [7:0] stat_t_q;
    logic [7:0] stat_ok_q;

    function automatic see_kind_e see_decode(input logic [7:0] op);
        see_kind_e k;
        k = K_NONE;
        if (op == OP_SET_LATCH) begin
            k = K_SET;
        end else if (op == OP_CLR_LATCH) begin
            k = K_CLR;
        end else if (op == OP_STAT_RD) begin
            k = K_SRD;
        end else if (op == OP_STAT_WR) begin
            k = K_SWR;
        end else if ((op & OP_MEM_MASK) == OP_MEM_RD) begin
            k = K_MRD;
        end else if ((op & OP_MEM_MASK) == OP_MEM_WR) begin
            k = K_MWR;
        end
        return k;
    endfunction : see_decode

    function automatic logic byte_end(input logic [2:0] c);
        return c == CNT_LAST;
    endfunction : byte_end

    // low nibble wraps inside the page, page bits hold
    function automatic logic [ADDR_W-1:0] page_step(
        input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:4], a[3:0] + 4'h1};
    endfunction : page_step

    function automatic logic [7:0] stat_pack(input see_ref_s r);
        return {SR_FILL, r.bp, r.wel, r.busy};
    endfunction : stat_pack

    ////////////////////////////////////////////////////////////////////
    // link side: bit capture and command decode
    always_comb begin
        lk_d   = lk_q;
        rec_d  = rec_q;
        buf_we = 1'b0;
        bin    = {lk_q.sh, si};
        if (pause_n) begin
            lk_d.live = 1'b1;
            if (!lk_q.live) begin
                rec_d = REC_RST;
            end
            lk_d.sh  = bin[6:0];
            lk_d.cnt = lk_q.cnt + 3'h1;
            case (lk_q.st)
                L_CMD: begin
                    if (byte_end(lk_q.cnt)) begin
                        lk_d.kind = see_decode(bin);
                        lk_d.addr = {HAS_UPPER & bin[X_BIT],
                                     8'h00};
                        if (stat_ok_q[0] && lk_d.kind != K_SRD) begin
                            lk_d.st = L_DROP;
                        end else begin
                            case (lk_d.kind)
                                K_SET: begin
                                    rec_d.set = 1'b1;
                                    lk_d.st   = L_DROP;
                                end
                                K_CLR: begin
                                    rec_d.clr = 1'b1;
                                    lk_d.st   = L_DROP;
                                end
                                K_SRD: begin
                                    lk_d.out = stat_ok_q;
                                    lk_d.st  = L_OUT;
                                end
                                K_SWR: begin
                                    lk_d.st = L_DATA;
                                end
                                K_MRD, K_MWR: begin
                                    lk_d.st = L_ADDR;
                                end
                                default: begin
                                    lk_d.st = L_DROP;
                                end
                            endcase
                        end
                    end
                end
                L_ADDR: begin
                    if (byte_end(lk_q.cnt)) begin
                        lk_d.addr = {lk_q.addr[ADDR_W-1], bin};
                        if (lk_q.kind == K_MRD) begin
                            lk_d.out = mem[lk_d.addr];
                            lk_d.st  = L_OUT;
                        end else begin
                            lk_d.st = L_DATA;
                        end
                    end
                end
                L_DATA: begin
                    if (byte_end(lk_q.cnt)) begin
                        if (lk_q.kind == K_SWR) begin
                            rec_d.swr = 1'b1;
                            rec_d.srb = bin;
                            lk_d.st   = L_DROP;
                        end else begin
                            buf_we                   = 1'b1;
                            rec_d.mwr                = 1'b1;
                            rec_d.mask[lk_q.addr[3:0]] = 1'b1;
                            rec_d.page  = lk_q.addr[ADDR_W-1:4];
                            lk_d.addr = page_step(lk_q.addr);
                        end
                    end
                end
                L_OUT: begin
                    if (byte_end(lk_q.cnt)) begin
                        if (lk_q.kind == K_MRD) begin
                            lk_d.addr = lk_q.addr + 9'h001;
                            lk_d.out  = mem[lk_d.addr];
                        end else begin
                            lk_d.out = stat_ok_q;
                        end
                    end
                end
                default: begin
                    lk_d.st = L_DROP;
                end
            endcase
        end
    end

    // frame state is cleared by the select line itself
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            lk_q <= LINK_RST;
        end else begin
            lk_q <= lk_d;
        end
    end

    // frame record must outlive the select rise
    always_ff @(posedge sclk) begin
        rec_q <= rec_d;
        if (buf_we) begin
            pbuf[lk_q.addr[3:0]] <= bin;
        end
    end

    assign stat_word = stat_pack(rf_q);

    always_comb begin
        sy_d   = sy_q;
        sy_d.m = stat_word;
        sy_d.s = sy_q.m;
    end

    always_ff @(posedge sclk) begin
        sy_q <= sy_d;
    end

    // multi-bit status: taken only once two samples agree
    always_ff @(posedge sclk) begin
        stat_t_q <= sy_q.s;
        if (sy_q.s == stat_t_q) begin
            stat_ok_q <= stat_t_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial output pin
    always_comb begin
        pin_d       = pin_q;
        pin_d.bit_o = lk_q.out[~lk_q.cnt];
        pin_d.oe_n  = !(lk_q.st == L_OUT && pause_n);
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            pin_q <= PIN_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core side: commit at select rise, self-timed write
    assign cs_rise = rf_q.cs_s & ~rf_q.cs_p;

    always_comb begin
        rf_d         = rf_q;
        mem_we       = 1'b0;
        rf_d.cs_m    = cs_n;
        rf_d.cs_s    = rf_q.cs_m;
        rf_d.cs_p    = rf_q.cs_s;
        rf_d.wg_m    = write_guard_n;
        rf_d.wg_s    = rf_q.wg_m;
        rf_d.standby = rf_q.cs_s & ~rf_q.busy;
        if (rf_q.busy) begin
            if (rf_q.tmr == '0) begin
                rf_d.busy = 1'b0;
            end else begin
                rf_d.tmr = rf_q.tmr - 1'b1;
            end
        end else if (cs_rise) begin
            if (rec_q.set) begin
                rf_d.wel = 1'b1;
            end
            if (rec_q.clr) begin
                rf_d.wel = 1'b0;
            end
            if ((rec_q.swr || rec_q.mwr) && rf_q.wel
                && rf_q.wg_s) begin
                rf_d.busy = 1'b1;
                rf_d.tmr  = TMR_W'(PROG_CYC - 1);
                rf_d.wel  = 1'b0;
                if (rec_q.swr) begin
                    rf_d.bp = rec_q.srb[SR_BP_LO +: 2];
                end
                mem_we = rec_q.mwr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rf_q <= REF_RST;
        end else begin
            rf_q <= rf_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (rec_q.mask[i]) begin
                    mem[{rec_q.page, 4'(i)}] <= pbuf[i];
                end
            end
        end
    end

    assign so      = pin_q.bit_o;
    assign so_oe_n = pin_q.oe_n;
    assign busy    = rf_q.busy;
    assign standby = rf_q.standby;

endmodule : see_cmd_port

// ===== verif/see_chk_asserts.sv
`timescale 1ns/10ps
module see_chk
    import see_pkg::*;
#(
    parameter int PROG_CYC = 50
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic pause_n,
    input wire logic write_guard_n,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic busy,
    input wire logic standby
);
    // length of the running self-timed write
    logic [31:0] run_q;
    always_ff @(posedge ref_clk) begin
        run_q <= (busy && !rst) ? run_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_cs_off; cs_n |-> so_oe_n; endproperty
    a_cs_off: assert property (p_cs_off) else $error("so on");
    property p_stby_sel; $fell(cs_n) |-> ##[1:4] !standby; endproperty
    a_stby_sel: assert property (p_stby_sel) else $error("stby");
    property p_stby_idle; (cs_n && !busy)[*6] |-> standby; endproperty
    a_stby_idle: assert property (p_stby_idle) else $error("idle");
    property p_stby_busy; busy ##1 busy |-> !standby; endproperty
    a_stby_busy: assert property (p_stby_busy) else $error("sb");
    property p_pause_off; $fell(pause_n) |-> ##[1:25] so_oe_n; endproperty
    a_pause_off: assert property (p_pause_off) else $error("pa");
    property p_so_edge; !so_oe_n && $changed(so) |-> !sclk; endproperty
    a_so_edge: assert property (p_so_edge) else $error("edge");
    property p_oe_edge;
        $fell(so_oe_n) |-> !cs_n && pause_n && !sclk;
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("oe");
    property p_busy_len; $fell(busy) |-> run_q == PROG_CYC; endproperty
    a_busy_len: assert property (p_busy_len) else $error("len");
    property p_busy_start; $rose(busy) |-> cs_n && $past(cs_n); endproperty
    a_busy_start: assert property (p_busy_start) else $error("st");
    property p_guard; $rose(busy) |-> $past(write_guard_n, 3); endproperty
    a_guard: assert property (p_guard) else $error("guard");
    c_busy: cover property ($rose(busy));
    c_out: cover property ($fell(so_oe_n));
    c_pause: cover property ($fell(pause_n));
endmodule : see_chk
bind see_cmd_port see_chk #(.PROG_CYC(PROG_CYC)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .pause_n(pause_n), .write_guard_n(write_guard_n), .so(so),
    .so_oe_n(so_oe_n), .busy(busy), .standby(standby));

// ===== verif/see_host.sv
`timescale 1ns/10ps
module see_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    output logic      pause_n,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic idle_q;
    logic oe_seen;
    initial begin
        {sclk, cs_n, si, pause_n, idle_q, oe_seen} = 6'h1c;
    end
    task automatic open_frame(input logic m3);
        idle_q  = m3;
        sclk    = m3;
        oe_seen = 1'b0;
        #40;
        cs_n = 1'b0;
        #40;
    endtask : open_frame
    // bits leave in the low phase, answers taken at the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk    = 1'b0;
            si      = tx[i];
            #62.5;
            sclk    = 1'b1;
            rx[i]   = so;
            oe_seen = oe_seen | !so_oe_n;
            #62.5;
        end
    endtask : xfer
    task automatic close_frame;
        sclk = idle_q;
        #62.5;
        cs_n = 1'b1;
        si   = ~si;
        #100;
    endtask : close_frame
    // clock runs on while paused, input toggles as noise
    task automatic pause_gap(output logic oe_p);
        sclk = 1'b0;
        #30;
        pause_n = 1'b0;
        repeat (4) begin
            #62.5;
            sclk = ~sclk;
            si   = ~si;
        end
        #30;
        oe_p    = so_oe_n;
        pause_n = 1'b1;
    endtask : pause_gap
endmodule : see_host

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb
    import see_pkg::*;
;
    localparam int PC = 800;
    logic       ref_clk;
    logic       rst;
    logic       write_guard_n;
    logic       oe_p;
    logic [7:0] r;
    wire        sclk, cs_n, si, pause_n, so, so_oe_n, busy, standby;
    int         n_fail = 0;
    int         check_count = 0;
    int         cyc = 0;
    see_cmd_port #(.PROG_CYC(PC)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
        .pause_n(pause_n), .write_guard_n(write_guard_n), .so(so),
        .so_oe_n(so_oe_n), .busy(busy), .standby(standby));
    see_host host_u (.sclk(sclk), .cs_n(cs_n), .si(si),
        .pause_n(pause_n), .so(so), .so_oe_n(so_oe_n));
    ////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    // sends the top n bytes of tx, returns the last byte seen
    task automatic frame(input logic m3, input logic [31:0] tx,
                         input int n, output logic [7:0] rx);
        host_u.open_frame(m3);
        for (int k = 0; k < n; k++) host_u.xfer(tx[31-8*k -: 8], rx);
        host_u.close_frame();
    endtask : frame
    task automatic pframe(input logic [31:0] tx);
        host_u.open_frame(1'b0);
        host_u.xfer(tx[31:24], r);
        host_u.xfer(tx[23:16], r);
        host_u.pause_gap(oe_p);
        host_u.xfer(tx[15:8], r);
        host_u.close_frame();
    endtask : pframe
    task automatic st(input logic [7:0] exp);
        frame(1'b0, 32'h0500_0000, 2, r);
        chk8(r, exp);
    endtask : st
    task automatic latch;
        frame(1'b0, 32'h0600_0000, 1, r);
    endtask : latch
    task automatic wr_go(input logic go);
        repeat (6) @(negedge ref_clk);
        chk8({7'h0, busy}, {7'h0, go});
    endtask : wr_go
    task automatic wr_done;
        for (int k = 0; k < PC + 10 && busy === 1'b1; k++) @(negedge ref_clk);
        chk8({7'h0, busy}, 8'h00);
    endtask : wr_done
    ////////////////////////////////////////////////////////////
    task automatic t_status;
        st(8'hf0);
        frame(1'b1, 32'h0600_0000, 1, r);
        st(8'hf2);
        frame(1'b0, 32'h0400_0000, 1, r);
        st(8'hf0);
    endtask : t_status
    task automatic t_write;
        latch();
        frame(1'b0, 32'h0aff_5aa5, 4, r);
        wr_go(1'b1);
        st(8'hf1);
        latch();
        wr_done();
        st(8'hf0);
        frame(1'b1, 32'h0bff_0000, 3, r);
        chk8(r, 8'h5a);
        frame(1'b1, 32'h0bf0_0000, 3, r);
        chk8(r, 8'ha5);
    endtask : t_write
    task automatic t_refuse;
        frame(1'b0, 32'h0af0_0000, 3, r);
        wr_go(1'b0);
        latch();
        @(negedge ref_clk) write_guard_n = 1'b0;
        frame(1'b0, 32'h0af0_3300, 3, r);
        wr_go(1'b0);
        @(negedge ref_clk) write_guard_n = 1'b1;
        frame(1'b0, 32'h0400_0000, 1, r);
        frame(1'b0, 32'h0bf0_0000, 3, r);
        chk8(r, 8'ha5);
    endtask : t_refuse
    task automatic t_pause;
        latch();
        pframe(32'h02f1_3c00);
        wr_go(1'b1);
        wr_done();
        frame(1'b0, 32'h03f1_0000, 3, r);
        chk8(r, 8'h3c);
        pframe(32'h03f1_0000);
        chk8({7'h0, oe_p}, 8'h01);
    endtask : t_pause
    task automatic t_unknown;
        logic [7:0] ops[6] = '{8'h00, 8'h07, 8'h0c, 8'h13, 8'h83, 8'hff};
        foreach (ops[i]) begin
            frame(1'b0, {ops[i], 8'h05, 16'h0}, 3, r);
            chk8({7'h0, host_u.oe_seen}, 8'h00);
        end
        st(8'hf0);
    endtask : t_unknown
    task automatic t_status_write_cmd;
        latch();
        frame(1'b0, 32'h010c_0000, 2, r);
        wr_go(1'b1);
        wr_done();
        st(8'hfc);
    endtask : t_status_write_cmd
    ////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        rst           = 1'b1;
        write_guard_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        t_status();
        t_write();
        t_refuse();
        t_pause();
        t_unknown();
        t_status_write_cmd();
        print_verdict();
    end
endmodule : tb
